// *** rsc_reset_source_controller.sv ***
// Reset source controller: gathers reset sources, sequences the internal
// reset, and holds the cause register.
// Assumes CPU strobes are on clk; pin, comparator, supply and watched clock
// are asynchronous and pass two flip-flops here.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] Watched clock level standing over 100 us resets when detector enabled.
// [RL2] Clock-loss flag bit 2 reads 1 only after a clock-loss reset.
// [RL3] Writing bit 2 enables or disables the clock-loss detector.
// [RL4] Only power-on and supply resets drive the reset pin low.
// [RL5] Writing bit 5 makes the comparator a reset source or removes it.
// [RL6] Enabled comparator output low holds the device in reset.
// [RL7] Comparator flag bit 5 reads 1 only after a comparator reset.
// [RL8] Firmware lets the comparator settle before enabling it as source.
// [RL9] Watchdog is forced enabled during reset and ticks at clock over 12.
// [RL10] Watchdog timeout resets; flag bit 3 then reads 1.
// [RL11] Program-store write above code limit resets with flash flag.
// [RL12] Code-memory read above the code limit resets with flash flag.
// [RL13] Fetch or branch above the code limit resets with flash flag.
// [RL14] Flash flag bit 6 reads 1 only after flash error reset, read-only.
// [RL15] Writing 1 to bit 4 forces reset; flag then reads 1.
// [RL16] Code starts at 0x0000 at least 5.0 us after release.
// [RL17] External circuitry holds the reset pin low at least 15 us.
// [RL18] Power-on flag bit 1 set by power-on or supply monitor reset.
// [RL19] Writing bit 1 enables or disables the supply monitor.
// [RL20] Pin flag bit 0 reads 1 only after a pin reset, read-only.
// [RL21] Bit 7 always reads zero; writes to it are ignored.
// [RL22] Firmware never uses read-modify-write on the cause register.
// [RL23] Any other reset clears the power-on flag.
// [RL24] Enabling a disabled supply monitor resets at once; re-enabling does not.
// [RL25] Leaving a pin reset sets the pin flag.
// [RL26] All flags update together per reset; enables keep their state.
module rsc_reset_source_controller #(
    parameter int CLK_LOSS_CYC = rsc_pkg::RSC_CLK_LOSS_CYC,
    parameter logic [15:0] USER_LIMIT = rsc_pkg::RSC_LIMIT_8K
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic cmp_out,
    input wire logic vdd_low,
    input wire logic clk_mon,
    input wire logic watchdog_timeout,
    input wire logic program_store_write_enable,
    input wire logic xdata_wr,
    input wire logic [15:0] xdata_addr,
    input wire logic code_rd,
    input wire logic [15:0] code_rd_addr,
    input wire logic fetch,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sys_reset,
    output logic cpu_run,
    output logic [15:0] reset_vector,
    output logic watchdog_force_enable,
    output logic watchdog_tick,
    output logic clock_loss_enable,
    output logic comparator_reset_enable,
    output logic vdd_monitor_enable
);
    typedef struct packed {
        rsc_pkg::rsc_state_t st;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [6:0] cause;
        logic clk_loss_en;
        logic cmp_en;
        logic vdd_en;
        logic [rsc_pkg::RSC_DLY_W-1:0] cnt;
        logic [7:0] rdata;
    } rsc_ctl_t;

    rsc_ctl_t q_ff;
    rsc_ctl_t nxt_q;

    logic clk_loss_ev;
    logic pin_low;
    logic cmp_low;
    logic vdd_fail;
    logic held;
    logic running;
    logic wr_hit;
    logic rd_hit;
    logic sw_ev;
    logic vdd_on_ev;
    logic wdog_ev;
    logic ferr_wr_ev;
    logic ferr_rd_ev;
    logic ferr_fetch_ev;
    logic ferr_ev;
    logic any_ev;

    // Priority encode of the reset cause: supply, pin, clock loss, comparator, watchdog, flash, software
    function automatic logic [6:0] rsc_cause(
        input logic vdd,
        input logic pin,
        input logic loss,
        input logic cmp,
        input logic wdog,
        input logic ferr,
        input logic sw
    );
        logic [6:0] c;
        c = '0;
        if (vdd) begin
            c[rsc_pkg::RSC_POS_POR] = 1'b1;
        end else if (pin) begin
            c[rsc_pkg::RSC_POS_PIN] = 1'b1;
        end else if (loss) begin
            c[rsc_pkg::RSC_POS_CLK_LOSS] = 1'b1;
        end else if (cmp) begin
            c[rsc_pkg::RSC_POS_COMPARATOR] = 1'b1;
        end else if (wdog) begin
            c[rsc_pkg::RSC_POS_WATCHDOG] = 1'b1;
        end else if (ferr) begin
            c[rsc_pkg::RSC_POS_FLASH] = 1'b1;
        end else if (sw) begin
            c[rsc_pkg::RSC_POS_SOFTWARE] = 1'b1;
        end
        return c;
    endfunction

    // Clock-loss one-shot on the synchronised watched clock
    rsc_clock_loss_timer #(
        .TIMEOUT_CYC(CLK_LOSS_CYC)
    ) u_clock_loss (
        .clk(clk),
        .rstn(rstn),
        .enable(q_ff.clk_loss_en),
        .mon(q_ff.sync2[rsc_pkg::RSC_SY_CLK]),
        .timeout(clk_loss_ev)
    );

    // Watchdog clock enable, realigned by every reset
    rsc_tick_divider #(
        .DIV(rsc_pkg::RSC_WDOG_DIV)
    ) u_wdog_div (
        .clk(clk),
        .rstn(rstn),
        .restart(sys_reset),
        .tick(watchdog_tick)
    );

    // Source decode from synchronised levels and CPU strobes
    always_comb begin
        running = (q_ff.st == rsc_pkg::RSC_ST_RUN);
        pin_low = ~q_ff.sync2[rsc_pkg::RSC_SY_PIN];
        cmp_low = q_ff.cmp_en & ~q_ff.sync2[rsc_pkg::RSC_SY_CMP]; // [RL6]
        vdd_fail = q_ff.vdd_en & q_ff.sync2[rsc_pkg::RSC_SY_VDD]; // [RL18]
        held = pin_low | cmp_low | vdd_fail;
        wr_hit = running & sfr_wr & (sfr_addr == rsc_pkg::RSC_ADDR_CAUSE);
        rd_hit = sfr_rd & (sfr_addr == rsc_pkg::RSC_ADDR_CAUSE);
        sw_ev = wr_hit & sfr_wdata[rsc_pkg::RSC_POS_SOFTWARE]; // [RL15]
        vdd_on_ev = wr_hit & sfr_wdata[rsc_pkg::RSC_POS_POR] & ~q_ff.vdd_en; // [RL24]
        wdog_ev = running & watchdog_timeout; // [RL10]
        ferr_wr_ev = running & xdata_wr & program_store_write_enable
            & (xdata_addr > USER_LIMIT); // [RL11]
        ferr_rd_ev = running & code_rd & (code_rd_addr > USER_LIMIT); // [RL12]
        ferr_fetch_ev = running & fetch & (fetch_addr > USER_LIMIT); // [RL13]
        ferr_ev = ferr_wr_ev | ferr_rd_ev | ferr_fetch_ev;
        any_ev = held | clk_loss_ev | wdog_ev | ferr_ev | sw_ev | vdd_on_ev;
    end

    // Sequencer, enables, cause flags and read data
    always_comb begin
        nxt_q = q_ff;
        nxt_q.sync1 = {clk_mon, vdd_low, cmp_out, rst_pin_in};
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.rdata = rd_hit ? {1'b0, q_ff.cause} : 8'h00; // [RL21]
        if (wr_hit) begin
            nxt_q.clk_loss_en = sfr_wdata[rsc_pkg::RSC_POS_CLK_LOSS]; // [RL3]
            nxt_q.cmp_en = sfr_wdata[rsc_pkg::RSC_POS_COMPARATOR]; // [RL5]
            nxt_q.vdd_en = sfr_wdata[rsc_pkg::RSC_POS_POR]; // [RL19]
        end
        case (q_ff.st)
            rsc_pkg::RSC_ST_HOLD: begin
                // Stay while a level source holds; first cause is kept
                if (!held) begin
                    nxt_q.st = rsc_pkg::RSC_ST_DELAY;
                    nxt_q.cnt = '0;
                end
            end
            rsc_pkg::RSC_ST_DELAY, rsc_pkg::RSC_ST_RUN: begin
                if (any_ev) begin
                    // All flags replaced at once by the newest cause
                    nxt_q.st = rsc_pkg::RSC_ST_HOLD; // [RL26]
                    nxt_q.cause = rsc_cause(vdd_fail | vdd_on_ev, pin_low, clk_loss_ev,
                        cmp_low, wdog_ev, ferr_ev, sw_ev); // [RL2] [RL7] [RL14] [RL20] [RL23] [RL25]
                end else if (q_ff.st == rsc_pkg::RSC_ST_DELAY) begin
                    if (q_ff.cnt == rsc_pkg::RSC_DLY_LAST) begin
                        nxt_q.st = rsc_pkg::RSC_ST_RUN; // [RL16]
                    end else begin
                        nxt_q.cnt = q_ff.cnt + 10'h001;
                    end
                end
            end
            default: begin
                nxt_q.st = rsc_pkg::RSC_ST_HOLD;
            end
        endcase
    end

    // State register; power-on clears enables and sets the power-on cause
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_ff.st <= rsc_pkg::RSC_ST_HOLD;
            q_ff.sync1 <= rsc_pkg::RSC_SYNC_RST;
            q_ff.sync2 <= rsc_pkg::RSC_SYNC_RST;
            q_ff.cause <= rsc_pkg::RSC_CAUSE_RST; // [RL18]
            q_ff.clk_loss_en <= rsc_pkg::RSC_EN_RST;
            q_ff.cmp_en <= rsc_pkg::RSC_EN_RST;
            q_ff.vdd_en <= rsc_pkg::RSC_EN_RST;
            q_ff.cnt <= '0;
            q_ff.rdata <= 8'h00;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Outputs; pin pulled low only for power-on and supply resets
    assign sys_reset = ~running;
    assign cpu_run = running;
    assign reset_vector = rsc_pkg::RSC_RESET_VECTOR; // [RL16]
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = ~(q_ff.cause[rsc_pkg::RSC_POS_POR] & ~running); // [RL4]
    assign watchdog_force_enable = sys_reset; // [RL9]
    assign sfr_rdata = q_ff.rdata;
    assign clock_loss_enable = q_ff.clk_loss_en;
    assign comparator_reset_enable = q_ff.cmp_en;
    assign vdd_monitor_enable = q_ff.vdd_en;

    // Checks on the reset sequencing
    a_pin_drive_por: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
        !rst_pin_oe_n |-> (sys_reset && q_ff.cause == 7'h02))
        else $error("reset pin driven for a non power-on cause");

    a_clk_loss_flag: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
        (clk_loss_ev && running && !held && !vdd_on_ev) |=> (sys_reset && sfr_rdata[7] == 1'b0
            && q_ff.cause == 7'h04))
        else $error("clock loss did not reset with its flag");

    a_sw_force: assert property (@(posedge clk) disable iff (!rstn) // [RL15]
        (sw_ev && !held && !clk_loss_ev && !wdog_ev && !ferr_ev && !vdd_on_ev)
            |=> (sys_reset && q_ff.cause == 7'h10))
        else $error("software force did not reset with its flag");

    a_cmp_source: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
        (running && cmp_low && !pin_low && !vdd_fail && !clk_loss_ev && !vdd_on_ev)
            |=> (sys_reset && q_ff.cause == 7'h20))
        else $error("comparator reset not taken or flag wrong");

    a_wdog_flag: assert property (@(posedge clk) disable iff (!rstn) // [RL10]
        (wdog_ev && !held && !clk_loss_ev && !vdd_on_ev)
            |=> (sys_reset && q_ff.cause == 7'h08))
        else $error("watchdog timeout did not reset with its flag");

    a_flash_error: assert property (@(posedge clk) disable iff (!rstn) // [RL13]
        (ferr_fetch_ev && !held && !clk_loss_ev && !wdog_ev && !vdd_on_ev) |=> (sys_reset
            && q_ff.cause[rsc_pkg::RSC_POS_FLASH] && $countones(q_ff.cause) == 1))
        else $error("fetch above code limit did not flag flash error");

    a_vdd_enable: assert property (@(posedge clk) disable iff (!rstn) // [RL24]
        (wr_hit && sfr_wdata[1] && q_ff.vdd_en && !held && !clk_loss_ev && !wdog_ev
            && !ferr_ev && !sfr_wdata[4]) |=> !sys_reset)
        else $error("re-enabling supply monitor caused a reset");

    a_flags_onehot: assert property (@(posedge clk) disable iff (!rstn) // [RL26]
        $changed(q_ff.cause) |-> ($onehot(q_ff.cause)
            && ($stable(q_ff.clk_loss_en) || $past(wr_hit))))
        else $error("cause flags not one-hot after update");

    a_start_delay: assert property (@(posedge clk) disable iff (!rstn) // [RL16]
        $rose(cpu_run) |-> ($past(q_ff.st) == rsc_pkg::RSC_ST_DELAY
            && $past(q_ff.cnt) == rsc_pkg::RSC_DLY_LAST))
        else $error("code started before the release delay");

    a_read_bit7: assert property (@(posedge clk) disable iff (!rstn) // [RL21]
        rd_hit |=> (sfr_rdata == {1'b0, $past(q_ff.cause)}))
        else $error("cause register read wrong");

    a_wdog_forced: assert property (@(posedge clk) disable iff (!rstn) // [RL9]
        sys_reset |-> (watchdog_force_enable ##1 !watchdog_tick))
        else $error("watchdog not forced on or divider not realigned in reset");
endmodule

`default_nettype wire

// *** rsc_pkg.sv ***
// Package of the reset source controller: register address, field positions,
// reset values and timing counts.
// Assumes a 200 MHz system clock and an 8-bit special-register port.
`default_nettype none

package rsc_pkg;

    // Clock rate
    localparam int RSC_CLK_MHZ = 200;
    localparam int RSC_CLK_PERIOD_NS = 5;

    // Special-register address of the cause register
    localparam logic [7:0] RSC_ADDR_CAUSE = 8'hEF;

    // Field positions inside reset_cause_status
    localparam int RSC_POS_PIN = 0;
    localparam int RSC_POS_POR = 1;
    localparam int RSC_POS_CLK_LOSS = 2;
    localparam int RSC_POS_WATCHDOG = 3;
    localparam int RSC_POS_SOFTWARE = 4;
    localparam int RSC_POS_COMPARATOR = 5;
    localparam int RSC_POS_FLASH = 6;
    localparam int RSC_CAUSE_W = 7;

    // Reset values: cause after power-on, enables off
    localparam logic [6:0] RSC_CAUSE_RST = 7'h02;
    localparam logic RSC_EN_RST = 1'b0;
    // Synchroniser idle levels: pin high, comparator high, supply good, clock low
    localparam logic [3:0] RSC_SYNC_RST = 4'h3;

    // Sync lane numbers
    localparam int RSC_SY_PIN = 0;
    localparam int RSC_SY_CMP = 1;
    localparam int RSC_SY_VDD = 2;
    localparam int RSC_SY_CLK = 3;

    // User code space limits for the three memory sizes
    localparam logic [15:0] RSC_LIMIT_8K = 16'h1DFF;
    localparam logic [15:0] RSC_LIMIT_4K = 16'h0FFF;
    localparam logic [15:0] RSC_LIMIT_2K = 16'h07FF;
    localparam logic [15:0] RSC_RESET_VECTOR = 16'h0000;

    // Clock-loss timeout, a least time: 100 us
    localparam int RSC_CLK_LOSS_US = 100;
    localparam int RSC_CLK_LOSS_CYC = RSC_CLK_LOSS_US * RSC_CLK_MHZ;

    // Delay from release to code execution, a least time: 5.0 us
    localparam int RSC_RST_DELAY_NS = 5000;
    localparam int RSC_RST_DELAY_CYC =
        (RSC_RST_DELAY_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
    localparam int RSC_DLY_W = 10;
    localparam logic [RSC_DLY_W-1:0] RSC_DLY_LAST = RSC_DLY_W'(RSC_RST_DELAY_CYC - 1);

    // Watchdog clock divider
    localparam int RSC_WDOG_DIV = 12;

    // Sequencer states
    typedef enum logic [2:0] {
        RSC_ST_HOLD = 3'h1,
        RSC_ST_DELAY = 3'h2,
        RSC_ST_RUN = 3'h4
    } rsc_state_t;

endpackage

`default_nettype wire

// *** rsc_tick_divider.sv ***
// Divider that gives a one-cycle enable pulse every DIV clocks.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module rsc_tick_divider #(
    parameter int DIV = rsc_pkg::RSC_WDOG_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic restart,
    output logic tick
);
    localparam int W = $clog2(DIV);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } rsc_div_t;

    rsc_div_t q_ff;
    rsc_div_t nxt_q;

    // Count modulo DIV, pulse on wrap
    always_comb begin
        nxt_q = q_ff;
        nxt_q.tick = 1'b0;
        if (restart) begin
            nxt_q.cnt = '0;
        end else if (q_ff.cnt == W'(DIV - 1)) begin
            nxt_q.cnt = '0;
            nxt_q.tick = 1'b1;
        end else begin
            nxt_q.cnt = q_ff.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign tick = q_ff.tick;
endmodule

`default_nettype wire

// *** rsc_clock_loss_timer.sv ***
// One-shot timer that fires when a watched clock level stands too long.
// Assumes mon is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module rsc_clock_loss_timer #(
    parameter int TIMEOUT_CYC = rsc_pkg::RSC_CLK_LOSS_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic mon,
    output logic timeout
);
    localparam int W = $clog2(TIMEOUT_CYC + 1);

    typedef struct packed {
        logic prev;
        logic fired;
        logic pulse;
        logic [W-1:0] cnt;
    } rsc_mcd_t;

    rsc_mcd_t q_ff;
    rsc_mcd_t nxt_q;

    // Any edge rearms; a level held TIMEOUT_CYC cycles fires once
    always_comb begin
        nxt_q = q_ff;
        nxt_q.prev = mon;
        nxt_q.pulse = 1'b0;
        if (!enable || (mon != q_ff.prev)) begin
            nxt_q.cnt = '0;
            nxt_q.fired = 1'b0;
        end else if (!q_ff.fired) begin
            if (q_ff.cnt == W'(TIMEOUT_CYC - 1)) begin
                nxt_q.pulse = 1'b1; // [RL1]
                nxt_q.fired = 1'b1;
            end else begin
                nxt_q.cnt = q_ff.cnt + W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign timeout = q_ff.pulse;
endmodule

`default_nettype wire

// *** rsc_fw_model.sv ***
// Firmware and on-chip source model driving the reset source controller.
// Assumes the controller samples every input on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none

module rsc_fw_model (
    input wire logic clk,
    input wire logic [7:0] sfr_rdata,
    output var logic rst_pin_in,
    output var logic cmp_out,
    output var logic vdd_low,
    output var logic clk_mon,
    output var logic watchdog_timeout,
    output var logic program_store_write_enable,
    output var logic xdata_wr,
    output var logic [15:0] xdata_addr,
    output var logic code_rd,
    output var logic [15:0] code_rd_addr,
    output var logic fetch,
    output var logic [15:0] fetch_addr,
    output var logic [7:0] sfr_addr,
    output var logic sfr_wr,
    output var logic [7:0] sfr_wdata,
    output var logic sfr_rd
);
    logic mon_run;

    // Idle levels: pin pulled up, comparator settled high, supply good
    initial begin
        mon_run = 1'b1;
        clk_mon = 1'b0;
        rst_pin_in = 1'b1;
        cmp_out = 1'b1;
        vdd_low = 1'b0;
        {watchdog_timeout, program_store_write_enable, xdata_wr, code_rd} = 4'h0;
        {fetch, sfr_wr, sfr_rd} = 3'h0;
        {xdata_addr, code_rd_addr, fetch_addr} = 48'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
    end

    // Watched clock toggles while running, stands still when stopped
    always @(negedge clk) begin
        if (mon_run) begin
            clk_mon <= ~clk_mon;
        end
    end

    // Whole-byte write strobe, never read-modify-write
    task automatic sfr_write(input logic [7:0] d);
        @(negedge clk);
        sfr_addr = rsc_pkg::RSC_ADDR_CAUSE;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_addr = 8'h10;
        sfr_wdata = ~d;
    endtask

    // Read strobe for one cycle; data taken the cycle after
    task automatic sfr_read(output logic [7:0] d);
        @(negedge clk);
        sfr_addr = rsc_pkg::RSC_ADDR_CAUSE;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_addr = 8'h10;
        d = sfr_rdata;
    endtask

    // One-cycle event: 0 watchdog, 1 data write, 2 code read, 3 fetch
    task automatic src_pulse(input int k, input logic [15:0] a);
        @(negedge clk);
        xdata_addr = a;
        code_rd_addr = a;
        fetch_addr = a;
        watchdog_timeout = (k == 0);
        xdata_wr = (k == 1);
        code_rd = (k == 2);
        fetch = (k == 3);
        @(negedge clk);
        {watchdog_timeout, xdata_wr, code_rd, fetch} = 4'h0;
        xdata_addr = ~a;
        code_rd_addr = ~a;
        fetch_addr = ~a;
    endtask

    // Level source active for n cycles: 0 pin, 1 comparator, 2 supply
    task automatic level_hold(input int k, input int n);
        @(negedge clk);
        rst_pin_in = (k != 0);
        cmp_out = (k != 1);
        vdd_low = (k > 1);
        repeat (n) @(negedge clk);
        rst_pin_in = 1'b1;
        cmp_out = 1'b1;
        vdd_low = 1'b0;
    endtask

    // Program-store write enable level, held until changed
    task automatic set_store_write(input logic en);
        program_store_write_enable = en;
    endtask

endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the reset source controller.
// Assumes the firmware model drives all source and register inputs.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk, rstn, rst_pin_in, cmp_out, vdd_low, clk_mon, watchdog_timeout;
    logic program_store_write_enable, xdata_wr, code_rd, fetch, sfr_wr, sfr_rd;
    logic [15:0] xdata_addr, code_rd_addr, fetch_addr, reset_vector;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic rst_pin_out, rst_pin_oe_n, sys_reset, cpu_run, watchdog_force_enable, watchdog_tick;
    logic clock_loss_enable, comparator_reset_enable, vdd_monitor_enable;
    int error_cnt;
    int samples_checked;

    rsc_reset_source_controller #(.CLK_LOSS_CYC(50)) rsc_reset_source_controller_inst (
        .clk(clk), .rstn(rstn), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n), .cmp_out(cmp_out), .vdd_low(vdd_low), .clk_mon(clk_mon),
        .watchdog_timeout(watchdog_timeout), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
        .program_store_write_enable(program_store_write_enable), .code_rd(code_rd),
        .code_rd_addr(code_rd_addr), .fetch(fetch), .fetch_addr(fetch_addr),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .sys_reset(sys_reset), .cpu_run(cpu_run),
        .reset_vector(reset_vector), .watchdog_force_enable(watchdog_force_enable),
        .watchdog_tick(watchdog_tick), .clock_loss_enable(clock_loss_enable),
        .comparator_reset_enable(comparator_reset_enable),
        .vdd_monitor_enable(vdd_monitor_enable));

    rsc_fw_model rsc_fw_model_inst (
        .clk(clk), .sfr_rdata(sfr_rdata), .rst_pin_in(rst_pin_in), .cmp_out(cmp_out),
        .vdd_low(vdd_low), .clk_mon(clk_mon), .watchdog_timeout(watchdog_timeout),
        .program_store_write_enable(program_store_write_enable), .xdata_wr(xdata_wr),
        .xdata_addr(xdata_addr), .code_rd(code_rd), .code_rd_addr(code_rd_addr),
        .fetch(fetch), .fetch_addr(fetch_addr), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts cycles until code may run, bounded
    task automatic wait_run(output int n);
        n = 0;
        while (cpu_run !== 1'b1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Reset entry, pin drive, delay, vector and recorded cause
    task automatic expect_reset(input string what, input logic [7:0] cause,
                                input logic oe_n, input int lim);
        int n;
        logic [7:0] d;
        n = 0;
        while (sys_reset !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        rsc_fw_model_inst.mon_run = 1'b1;
        check({what, " entry"}, sys_reset, 1'b1);
        @(negedge clk);
        check({what, " pin drive"}, {rst_pin_oe_n, rst_pin_out}, {oe_n, 1'b0});
        check({what, " wdog force"}, watchdog_force_enable, 1'b1);
        wait_run(n);
        check({what, " delay"}, n >= 1000, 1'b1);
        check({what, " vector"}, reset_vector, 16'h0000);
        rsc_fw_model_inst.sfr_read(d);
        check({what, " cause"}, d, cause);
    endtask

    // No reset may follow
    task automatic quiet(input string what);
        repeat (6) @(negedge clk);
        check(what, sys_reset, 1'b0);
    endtask

    // Power-on reset and its flag
    task automatic t_por();
        check("por pin", rst_pin_oe_n, 1'b0);
        rstn = 1'b1;
        expect_reset("por", 8'h02, 1'b0, 8);
        check("por enables", {clock_loss_enable, comparator_reset_enable, vdd_monitor_enable},
              3'h0);
        $display("Test por done");
    endtask

    // Software force, zero write ignored
    task automatic t_soft();
        rsc_fw_model_inst.sfr_write(8'h00);
        quiet("soft zero");
        rsc_fw_model_inst.sfr_write(8'h10);
        expect_reset("soft", 8'h10, 1'b1, 8);
        $display("Test soft done");
    endtask

    // Clock loss and comparator sources, enabled and disabled
    task automatic t_clk_cmp();
        rsc_fw_model_inst.sfr_write(8'h24);
        @(negedge clk);
        check("enables", {clock_loss_enable, comparator_reset_enable}, 2'h3);
        rsc_fw_model_inst.mon_run = 1'b0;
        expect_reset("clock loss", 8'h04, 1'b1, 80);
        check("kept", {clock_loss_enable, comparator_reset_enable}, 2'h3);
        fork
            rsc_fw_model_inst.level_hold(1, 20);
            expect_reset("cmp", 8'h20, 1'b1, 8);
        join
        rsc_fw_model_inst.sfr_write(8'h00);
        rsc_fw_model_inst.mon_run = 1'b0;
        rsc_fw_model_inst.level_hold(1, 20);
        repeat (80) @(negedge clk);
        quiet("sources off");
        rsc_fw_model_inst.mon_run = 1'b1;
        $display("Test clock and comparator done");
    endtask

    // Watchdog timeout and watchdog clock divider
    task automatic t_wdog();
        int t;
        rsc_fw_model_inst.src_pulse(0, 16'h0000);
        expect_reset("wdog", 8'h08, 1'b1, 8);
        t = 0;
        repeat (120) begin
            @(negedge clk);
            t += int'(watchdog_tick);
        end
        check("wdog ticks", t, 10);
        $display("Test watchdog done");
    endtask

    // Illegal code-space accesses and read-only bits
    task automatic t_flash();
        logic [7:0] d;
        rsc_fw_model_inst.src_pulse(1, 16'hFFFF);
        rsc_fw_model_inst.src_pulse(3, rsc_pkg::RSC_LIMIT_8K);
        quiet("flash legal");
        rsc_fw_model_inst.set_store_write(1'b1);
        for (int k = 1; k < 4; k++) begin
            rsc_fw_model_inst.src_pulse(k, rsc_pkg::RSC_LIMIT_8K + 16'h0001);
            expect_reset("flash", 8'h40, 1'b1, 8);
        end
        rsc_fw_model_inst.set_store_write(1'b0);
        rsc_fw_model_inst.sfr_write(8'hC9);
        quiet("ro write");
        rsc_fw_model_inst.sfr_read(d);
        check("ro bits", d, 8'h40);
        $display("Test flash done");
    endtask

    // External pin reset held for the minimum low time
    task automatic t_pin();
        fork
            rsc_fw_model_inst.level_hold(0, 3000);
            expect_reset("pin", 8'h01, 1'b1, 8);
        join
        $display("Test pin done");
    endtask

    // Supply monitor enable, re-enable and low supply
    task automatic t_vdd();
        rsc_fw_model_inst.sfr_write(8'h02);
        expect_reset("vdd enable", 8'h02, 1'b0, 8);
        check("vdd en", vdd_monitor_enable, 1'b1);
        rsc_fw_model_inst.sfr_write(8'h02);
        quiet("vdd again");
        fork
            rsc_fw_model_inst.level_hold(2, 20);
            expect_reset("vdd low", 8'h02, 1'b0, 8);
        join
        rsc_fw_model_inst.sfr_write(8'h00);
        @(negedge clk);
        check("vdd off", vdd_monitor_enable, 1'b0);
        $display("Test vdd done");
    endtask

    // Counts and verdict
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, about twice the expected run
    initial begin
        #150000;
        error_cnt++;
        wrap_up();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk);
        t_por();
        t_soft();
        t_clk_cmp();
        t_wdog();
        t_flash();
        t_pin();
        t_vdd();
        wrap_up();
    end

endmodule

`default_nettype wire
